// ### emr_regs.vh
// Register offsets, field positions and reset values of the external memory read sequencer
`ifndef EMR_REGS_VH
`define EMR_REGS_VH
`define EMR_ADDR_W 8
`define EMR_OFS_CTRL 8'h00
`define EMR_OFS_PARAM 8'h04
`define EMR_OFS_ADDR 8'h08
`define EMR_OFS_STATUS 8'h0C
`define EMR_OFS_DATA 8'h10
`define EMR_CTRL_DIV_HI 2
`define EMR_CTRL_DIV_LO 0
`define EMR_CTRL_START 8
`define EMR_PAR_LATCH_HI 14
`define EMR_PAR_LATCH_LO 12
`define EMR_PAR_ADDR_HOLD 10
`define EMR_PAR_READ_HOLD 9
`define EMR_PAR_RDW_HI 3
`define EMR_PAR_RDW_LO 0
`define EMR_STAT_BUSY 0
`define EMR_STAT_DONE 1
`define EMR_DIV_RESET 3'h0
`define EMR_PAR_RESET 16'h0000
`define EMR_HALF_ONE 6'h01
`define EMR_HALF_ZERO 6'h00
`endif

// ### emr_half_tick.v
// Half-period tick divider of the external memory interface clock
`timescale 1ns/1ps
`default_nettype none
module emr_half_tick #(
    parameter BASE_HALF_CYCLES = 1
) (
    input wire clk_sys,
    input wire reset,
    input wire run,
    input wire [2:0] coreClockDivider,
    output reg halfTick
);
    // ----------------------------------------
    // Tick every (divider+1) base half periods
    // ----------------------------------------
    reg [7:0] count;
    wire [31:0] divPlusOne = {29'h0000_0000, coreClockDivider} + 32'h0000_0001;
    wire [31:0] limitWide = (divPlusOne * BASE_HALF_CYCLES) - 32'h0000_0001;
    wire [7:0] limit = limitWide[7:0];
    // Combinational tick so the first one lands one half period after start
    always @* begin
        halfTick = run && (count >= limit);
    end
    always @(posedge clk_sys) begin
        if (reset || !run) begin
            count <= 8'h00;
        end else if (halfTick) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule // emr_half_tick
`default_nettype wire

// ### emr_read_cycle.v
// External memory read-cycle sequencer with its register port
//
// Added by the designer: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "emr_regs.vh"
// Behaviour
// - Interface clock period is the base period times the divider field plus one.
// - The address-latch enable stays high for the latch-width field plus one clocks.
// - Address stays valid half a clock after latch enable falls, plus a clock if address-hold is clear.
// - Read strobe falls half a clock after latch enable falls, plus a clock per cleared hold bit.
// - Read strobe stays low for the read-width field plus one clocks.
// - A cleared read-hold bit lengthens the data hold window after read strobe rises by a clock.
module emr_read_cycle #(
    parameter BASE_HALF_CYCLES = 1,
    parameter ADDR_W = 19,
    parameter DATA_W = 16
) (
    input wire clk_sys,
    input wire reset,
    input wire [`EMR_ADDR_W-1:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdData,
    output reg memorySelectStrobeN,
    output reg addressLatchEnable,
    output reg readStrobeN,
    output reg [ADDR_W-1:0] memAddr,
    output reg memAddrOe,
    output reg dataHoldWindow,
    input wire [DATA_W-1:0] memDataIn
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_IDLE = 7'h01;
    localparam S_SEL = 7'h02;
    localparam S_ALE = 7'h04;
    localparam S_AHLD = 7'h08;
    localparam S_GAP = 7'h10;
    localparam S_RD = 7'h20;
    localparam S_REL = 7'h40;

    reg [6:0] state;
    reg [5:0] halfCnt;
    reg [2:0] coreClockDivider;
    reg [15:0] regionTimingParams;
    reg [ADDR_W-1:0] addrReg;
    reg [DATA_W-1:0] dataReg;
    reg done;
    reg [DATA_W-1:0] sync1, sync2, sync3;
    wire halfTick;
    wire [2:0] latchW = regionTimingParams[`EMR_PAR_LATCH_HI:`EMR_PAR_LATCH_LO];
    wire [3:0] readW = regionTimingParams[`EMR_PAR_RDW_HI:`EMR_PAR_RDW_LO];
    wire addrHoldClr = !regionTimingParams[`EMR_PAR_ADDR_HOLD];
    wire readHoldClr = !regionTimingParams[`EMR_PAR_READ_HOLD];
    wire busy = !state[0];
    wire startReq = regWrite && (regAddr == `EMR_OFS_CTRL) && regWrData[`EMR_CTRL_START];
    wire phaseEnd = halfTick && (halfCnt == `EMR_HALF_ZERO);
    wire dataStable = (sync2 == sync3);
    // Phase lengths in half periods, minus one
    wire [5:0] aleLen = {2'b00, latchW, 1'b1};
    wire [5:0] ahldLen = {4'h0, addrHoldClr, 1'b0};
    wire [5:0] rdLen = {1'b0, readW, 1'b1};

    emr_half_tick #(.BASE_HALF_CYCLES(BASE_HALF_CYCLES)) uTick (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(busy),
        .coreClockDivider(coreClockDivider),
        .halfTick(halfTick)
    );

    // ----------------------------------------
    // Data pin synchroniser
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            sync1 <= {DATA_W{1'b0}};
            sync2 <= {DATA_W{1'b0}};
            sync3 <= {DATA_W{1'b0}};
        end else begin
            sync1 <= memDataIn;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // ----------------------------------------
    // Read-cycle sequencer
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            state <= S_IDLE;
            halfCnt <= `EMR_HALF_ZERO;
            memorySelectStrobeN <= 1'b1;
            addressLatchEnable <= 1'b0;
            readStrobeN <= 1'b1;
            memAddr <= {ADDR_W{1'b0}};
            memAddrOe <= 1'b0;
            dataHoldWindow <= 1'b0;
            dataReg <= {DATA_W{1'b0}};
        end else begin
            case (state)
                S_IDLE: begin
                    dataHoldWindow <= 1'b0;
                    if (startReq) begin
                        state <= S_SEL;
                        halfCnt <= `EMR_HALF_ZERO;
                        memorySelectStrobeN <= 1'b0;
                        memAddr <= addrReg;
                        memAddrOe <= 1'b1;
                    end
                end
                S_SEL: begin
                    if (phaseEnd) begin
                        state <= S_ALE;
                        halfCnt <= aleLen;
                        addressLatchEnable <= 1'b1;
                    end
                end
                S_ALE: begin
                    if (phaseEnd) begin
                        state <= S_AHLD;
                        halfCnt <= ahldLen;
                        addressLatchEnable <= 1'b0;
                    end else if (halfTick) begin
                        halfCnt <= halfCnt - `EMR_HALF_ONE;
                    end
                end
                S_AHLD: begin
                    if (phaseEnd) begin
                        memAddrOe <= 1'b0;
                        if (readHoldClr) begin
                            state <= S_GAP;
                            halfCnt <= `EMR_HALF_ONE;
                        end else begin
                            state <= S_RD;
                            halfCnt <= rdLen;
                            readStrobeN <= 1'b0;
                        end
                    end else if (halfTick) begin
                        halfCnt <= halfCnt - `EMR_HALF_ONE;
                    end
                end
                S_GAP: begin
                    if (phaseEnd) begin
                        state <= S_RD;
                        halfCnt <= rdLen;
                        readStrobeN <= 1'b0;
                    end else if (halfTick) begin
                        halfCnt <= halfCnt - `EMR_HALF_ONE;
                    end
                end
                S_RD: begin
                    if (phaseEnd) begin
                        state <= S_REL;
                        halfCnt <= `EMR_HALF_ONE;
                        readStrobeN <= 1'b1;
                        dataHoldWindow <= readHoldClr;
                    end else if (halfTick) begin
                        halfCnt <= halfCnt - `EMR_HALF_ONE;
                    end
                    if (dataStable) begin
                        dataReg <= sync3;
                    end
                end
                S_REL: begin
                    if (phaseEnd) begin
                        state <= S_IDLE;
                        memorySelectStrobeN <= 1'b1;
                        dataHoldWindow <= 1'b0;
                    end else if (halfTick) begin
                        halfCnt <= halfCnt - `EMR_HALF_ONE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            coreClockDivider <= `EMR_DIV_RESET;
            regionTimingParams <= `EMR_PAR_RESET;
            addrReg <= {ADDR_W{1'b0}};
            done <= 1'b0;
            regRdData <= 32'h0000_0000;
        end else begin
            if (regWrite && !busy) begin
                if (regAddr == `EMR_OFS_CTRL) begin
                    coreClockDivider <= regWrData[`EMR_CTRL_DIV_HI:`EMR_CTRL_DIV_LO];
                end
                if (regAddr == `EMR_OFS_PARAM) begin
                    regionTimingParams <= regWrData[15:0];
                end
                if (regAddr == `EMR_OFS_ADDR) begin
                    addrReg <= regWrData[ADDR_W-1:0];
                end
            end
            // Completion sets done; set wins over a clear in the same cycle
            if (state[6] && phaseEnd) begin
                done <= 1'b1;
            end else if (regWrite && (regAddr == `EMR_OFS_STATUS) && regWrData[`EMR_STAT_DONE]) begin
                done <= 1'b0;
            end
            regRdData <= 32'h0000_0000;
            if (regRead) begin
                case (regAddr)
                    `EMR_OFS_CTRL: regRdData <= {29'h0000_0000, coreClockDivider};
                    `EMR_OFS_PARAM: regRdData <= {16'h0000, regionTimingParams};
                    `EMR_OFS_ADDR: regRdData <= {{(32-ADDR_W){1'b0}}, addrReg};
                    `EMR_OFS_STATUS: regRdData <= {30'h0000_0000, done, busy};
                    `EMR_OFS_DATA: regRdData <= {{(32-DATA_W){1'b0}}, dataReg};
                    default: regRdData <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // emr_read_cycle
`default_nettype wire

// ### emr_read_cycle_monitor.sv
// Checker of the read sequencer strobe relations
`timescale 1ns/1ps
`default_nettype none
module emr_read_cycle_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    input wire logic memorySelectStrobeN,
    input wire logic addressLatchEnable,
    input wire logic readStrobeN,
    input wire logic memAddrOe,
    input wire logic dataHoldWindow
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_ale_in_select: assert property (addressLatchEnable |-> !memorySelectStrobeN)
        else $error("latch enable outside select");
    a_select_start: assert property ($fell(memorySelectStrobeN) |-> memAddrOe && !addressLatchEnable)
        else $error("select start wrong");
    a_ale_width: assert property ($rose(addressLatchEnable) |-> addressLatchEnable[*2])
        else $error("latch enable too short");
    a_rd_after_ale: assert property (!readStrobeN |-> !addressLatchEnable && !memAddrOe)
        else $error("read strobe overlaps address phase");
    a_rd_width: assert property ($fell(readStrobeN) |-> !readStrobeN[*2])
        else $error("read strobe too short");
    a_hold_window: assert property (dataHoldWindow |-> readStrobeN && !memorySelectStrobeN)
        else $error("hold window misplaced");
    a_release_gap: assert property ($rose(readStrobeN) |-> !memorySelectStrobeN[*2])
        else $error("select released early");
    a_rd_in_select: assert property (!readStrobeN |-> !memorySelectStrobeN)
        else $error("read strobe outside select");
    a_rd_data_pulse: assert property (!$past(regRead) |-> regRdData == 32'h0000_0000)
        else $error("read data outside answer cycle");
endmodule // emr_read_cycle_monitor
bind emr_read_cycle emr_read_cycle_monitor u_emr_read_cycle_monitor (.clk_sys(clk_sys),
    .reset(reset), .regRead(regRead), .regRdData(regRdData),
    .memorySelectStrobeN(memorySelectStrobeN), .addressLatchEnable(addressLatchEnable),
    .readStrobeN(readStrobeN), .memAddrOe(memAddrOe), .dataHoldWindow(dataHoldWindow));
`default_nettype wire

// ### emr_mem_model.sv
// Asynchronous memory model on the read bus
`timescale 1ns/1ps
`default_nettype none
module emr_mem_model #(
    parameter ADDR_W = 19
) (
    input wire logic clk_sys,
    input wire logic readStrobeN,
    input wire logic dataHoldWindow,
    input wire logic [ADDR_W-1:0] memAddr,
    output wire logic [15:0] memDataIn
);
    logic [15:0] idle = 16'h0000;
    // Drives while strobe low and through hold window, else a toggling pattern
    assign memDataIn = (!readStrobeN || dataHoldWindow) ? (memAddr[15:0] ^ 16'hA5C3) : idle;
    always @(posedge clk_sys) begin
        idle <= ~memDataIn;
    end
endmodule // emr_mem_model
`default_nettype wire

// ### emr_read_cycle_tb_top.sv
// Testbench of the external memory read sequencer
`timescale 1ns/1ps
`default_nettype none
`include "emr_regs.vh"
module emr_read_cycle_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [31:0] regRdData;
    logic msN, ale, rdN, oe, hold;
    logic [18:0] memAddr, aAle;
    logic [15:0] memDataIn;
    int failures = 0, tests_run = 0, cyc = 0, tAleR, tAleF, tOeF, tRdF, tRdR, tMsR, holdCnt;
    int tMsF = 0;
    logic ended = 1'b0;
    emr_read_cycle u_emr_read_cycle (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .memorySelectStrobeN(msN), .addressLatchEnable(ale), .readStrobeN(rdN),
        .memAddr(memAddr), .memAddrOe(oe), .dataHoldWindow(hold), .memDataIn(memDataIn));
    emr_mem_model u_emr_mem_model (.clk_sys(clk_sys), .readStrobeN(rdN),
        .dataHoldWindow(hold), .memAddr(memAddr), .memDataIn(memDataIn));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ------------------------------
    // Phase timestamps
    // ------------------------------
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (regWrite && (regAddr == `EMR_OFS_CTRL) && regWrData[`EMR_CTRL_START]) begin
            holdCnt <= 0;
            ended <= 1'b0;
        end else begin
            holdCnt <= holdCnt + hold;
        end
        if ($fell(msN)) tMsF <= cyc;
        if ($rose(ale)) begin
            tAleR <= cyc;
            aAle <= memAddr;
        end
        if ($fell(ale)) tAleF <= cyc;
        if ($fell(oe)) tOeF <= cyc;
        if ($fell(rdN)) tRdF <= cyc;
        if ($rose(rdN)) tRdR <= cyc;
        if ($rose(msN)) begin
            tMsR <= cyc;
            ended <= 1'b1;
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 check("regRdData", regRdData, exp);
    endtask
    // One read cycle with phase measurement
    task automatic run(input logic [2:0] d, input logic [15:0] p, input logic [18:0] a);
        int h;
        h = d + 1;
        wr(`EMR_OFS_PARAM, {16'h0000, p});
        wr(`EMR_OFS_ADDR, {13'h0000, a});
        wr(`EMR_OFS_CTRL, {23'h00_0000, 1'b1, 5'h00, d});
        wr(`EMR_OFS_PARAM, 32'h0000_FFFF);
        rd(`EMR_OFS_STATUS, 32'h0000_0001);
        for (int i = 0; i < 4000 && ended !== 1'b1; i++) @(posedge clk_sys);
        @(posedge clk_sys);
        check("cycleEnd", {31'h0000_0000, ended}, 32'h0000_0001);
        check("selToAle", tAleR - tMsF, h);
        check("memAddr", {13'h0000, aAle}, {13'h0000, a});
        check("aleHigh", tAleF - tAleR, 2 * (p[14:12] + 1) * h);
        check("addrHold", tOeF - tAleF, (1 + 2 * !p[10]) * h);
        check("rdDelay", tRdF - tAleF, (1 + 2 * !p[10] + 2 * !p[9]) * h);
        check("rdLow", tRdR - tRdF, 2 * (p[3:0] + 1) * h);
        check("holdWin", holdCnt, p[9] ? 0 : 2 * h);
        check("release", tMsR - tRdR, 2 * h);
        rd(`EMR_OFS_PARAM, {16'h0000, p});
        if (2 * (p[3:0] + 1) * h >= 4) rd(`EMR_OFS_DATA, {16'h0000, a[15:0] ^ 16'hA5C3});
        rd(`EMR_OFS_STATUS, 32'h0000_0002);
        wr(`EMR_OFS_STATUS, 32'h0000_0002);
        rd(`EMR_OFS_STATUS, 32'h0000_0000);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        conclude();
    end
    // ------------------------------
    // Test sequence
    // ------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`EMR_OFS_PARAM, 32'h0000_0000);
        rd(`EMR_OFS_ADDR, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        run(3'h0, 16'h0600, 19'h1_2345);
        run(3'h1, 16'h0000, 19'h7_FFFF);
        run(3'h2, 16'h760F, 19'h0_0001);
        run(3'h0, 16'h2403, 19'h5_A5A5);
        run(3'h7, 16'h0200, 19'h3_0F0F);
        conclude();
    end
endmodule // emr_read_cycle_tb_top
`default_nettype wire
